// File: core/lcd_driver.sv
module lcd_driver #(
   parameter int NUM_COM = lcd_pkg::NUM_COM,
   parameter int NUM_SEG = lcd_pkg::NUM_SEG,
   parameter int ADDR_W = 5
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic prescaler_output,
   input wire logic timer5_bit4,
   input wire logic backup_mode,
   input wire logic display_control_first_we,
   input wire logic [3:0] display_control_first_wdata,
   input wire logic display_control_second_we,
   input wire logic [3:0] display_control_second_wdata,
   input wire logic timer_control_six_we,
   input wire logic [3:0] timer_control_six_wdata,
   input wire logic display_divider_timer_we,
   input wire logic [3:0] display_divider_timer_wdata,
   input wire logic ram_we,
   input wire logic [ADDR_W-1:0] ram_addr,
   input wire logic [NUM_COM-1:0] ram_wdata,
   output logic [NUM_COM-1:0][1:0] common_outputs_level,
   output logic [NUM_COM-1:0] common_outputs_oe,
   output logic [NUM_SEG-1:0][1:0] segment_outputs_level,
   output logic [lcd_pkg::NUM_SHARED-1:0] shared_segment_outputs_oe,
   output logic [lcd_pkg::NUM_SHARED-1:0] internal_supply_sel,
   output logic divider_resistor_en,
   output logic divider_resistor_low,
   output logic display_clock,
   output logic display_active,
   output logic [1:0] scan_com_index
);
   logic [3:0] cf_q, cf_d, cs_q, cs_d, tc_q, tc_d, dv_q, dv_d;
   logic t5_q, t5_d;
   logic [NUM_SEG-1:0][NUM_COM-1:0] ram_q, ram_d;
   lcd_pkg::lcd_state_t st_q, st_d;
   logic [1:0] idx_q, idx_d;
   logic pol_q, pol_d;
   logic [NUM_COM-1:0][1:0] com_d;
   logic [NUM_COM-1:0] com_oe_d;
   logic [NUM_SEG-1:0][1:0] seg_d;
   logic src_tick, disp_tick, cfg_ok, third_bias;
   logic [1:0] duty, last_idx;

   // Control registers and RAM storage
   always_comb begin
      cf_d = cf_q;
      cs_d = cs_q;
      tc_d = tc_q;
      dv_d = dv_q;
      ram_d = ram_q;
      t5_d = timer5_bit4;
      if (display_control_first_we) begin
         cf_d = display_control_first_wdata;
      end
      if (display_control_second_we) begin
         cs_d = display_control_second_wdata;
      end
      if (timer_control_six_we) begin
         tc_d = timer_control_six_wdata;
      end
      if (display_divider_timer_we) begin
         dv_d = display_divider_timer_wdata;
      end
      // Write one RAM word per segment
      if (ram_we && ram_addr < ADDR_W'(NUM_SEG)) begin
         ram_d[ram_addr] = ram_wdata;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cf_q <= lcd_pkg::CF_RESET;
         cs_q <= lcd_pkg::CS_RESET;
         tc_q <= lcd_pkg::TC_RESET;
         dv_q <= lcd_pkg::DIV_RESET;
         ram_q <= '0;
         t5_q <= 1'b0;
      end else begin
         cf_q <= cf_d;
         cs_q <= cs_d;
         tc_q <= tc_d;
         dv_q <= dv_d;
         ram_q <= ram_d;
         t5_q <= t5_d;
      end
   end

   assign src_tick = tc_q[lcd_pkg::TC_SRC_SEL] ? prescaler_output : (timer5_bit4 & ~t5_q);

   lcd_divider #(.CNT_W(4)) u_div (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(tc_q[lcd_pkg::TC_RUN]),
      .src_tick(src_tick),
      .reload(dv_q),
      .display_clock(display_clock),
      .disp_tick(disp_tick)
   );

   assign duty = cf_q[lcd_pkg::CF_DUTY_LSB +: 2];
   // Last scanned common equals duty code
   assign last_idx = duty;
   assign third_bias = (duty != lcd_pkg::DUTY_HALF);
   assign cfg_ok = cf_q[lcd_pkg::CF_DRIVE_ON] && (duty != lcd_pkg::DUTY_NONE) && !backup_mode;

   // Scan sequencer
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      pol_d = pol_q;
      unique case (st_q)
         lcd_pkg::LCD_ST_OFF: begin
            idx_d = 2'h0;
            pol_d = 1'b0;
            if (cfg_ok) begin
               st_d = lcd_pkg::LCD_ST_SCAN;
            end
         end
         lcd_pkg::LCD_ST_SCAN: begin
            if (!cfg_ok) begin
               st_d = lcd_pkg::LCD_ST_OFF;
            end else if (disp_tick) begin
               if (idx_q >= last_idx) begin
                  idx_d = 2'h0;
                  pol_d = ~pol_q;
               end else begin
                  idx_d = idx_q + 2'h1;
               end
            end
         end
         default: begin
            st_d = lcd_pkg::LCD_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= lcd_pkg::LCD_ST_OFF;
         idx_q <= 2'h0;
         pol_q <= 1'b0;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         pol_q <= pol_d;
      end
   end

   for (genvar c = 0; c < NUM_COM; c++) begin : g_com
      assign com_d[c] = (st_q != lcd_pkg::LCD_ST_SCAN) ? lcd_pkg::LVL_TOP :
                        (idx_q == 2'(c)) ? (pol_q ? lcd_pkg::LVL_0 : lcd_pkg::LVL_TOP) :
                        !third_bias ? lcd_pkg::LVL_1 :
                        (pol_q ? lcd_pkg::LVL_2 : lcd_pkg::LVL_1);
      assign com_oe_d[c] = (st_q != lcd_pkg::LCD_ST_SCAN) || (2'(c) <= last_idx);
   end

   for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      assign seg_d[s] = (st_q != lcd_pkg::LCD_ST_SCAN) ? lcd_pkg::LVL_TOP :
                        ram_q[s][idx_q] ? (pol_q ? lcd_pkg::LVL_TOP : lcd_pkg::LVL_0) :
                        !third_bias ? (pol_q ? lcd_pkg::LVL_0 : lcd_pkg::LVL_TOP) :
                        (pol_q ? lcd_pkg::LVL_1 : lcd_pkg::LVL_2);
   end

   // Output levels start at top level
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         common_outputs_level <= {NUM_COM{lcd_pkg::LVL_TOP}};
         common_outputs_oe <= '1;
         segment_outputs_level <= {NUM_SEG{lcd_pkg::LVL_TOP}};
      end else begin
         common_outputs_level <= com_d;
         common_outputs_oe <= com_oe_d;
         segment_outputs_level <= seg_d;
      end
   end

   // Shared pin role and supply source
   for (genvar p = 0; p < lcd_pkg::NUM_SHARED; p++) begin : g_shared
      assign shared_segment_outputs_oe[p] = ~cs_q[lcd_pkg::CS_SHARED_TOP - p];
      assign internal_supply_sel[p] = ~cs_q[lcd_pkg::CS_SHARED_TOP - p];
   end

   assign divider_resistor_en = ~cs_q[lcd_pkg::CS_RES_CTL];
   assign divider_resistor_low = cf_q[lcd_pkg::CF_RES_SEL];
   assign display_active = (st_q == lcd_pkg::LCD_ST_SCAN);
   assign scan_com_index = idx_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   off_top_level_a: assert property ($past(st_q) == lcd_pkg::LCD_ST_OFF |->
      common_outputs_level == {NUM_COM{lcd_pkg::LVL_TOP}} &&
      segment_outputs_level == {NUM_SEG{lcd_pkg::LVL_TOP}})
      else $error("outputs not at top level while off");
   bad_duty_off_a: assert property (duty == lcd_pkg::DUTY_NONE || !cf_q[lcd_pkg::CF_DRIVE_ON]
      |=> st_q == lcd_pkg::LCD_ST_OFF)
      else $error("scanning with invalid duty or drive off");
   unused_com_open_a: assert property ($past(st_q) == lcd_pkg::LCD_ST_SCAN
      && $past(duty) == lcd_pkg::DUTY_HALF |-> common_outputs_oe[3:2] == 2'b00)
      else $error("unused common driven at half duty");
   index_range_a: assert property (st_q == lcd_pkg::LCD_ST_SCAN && $stable(duty) && $past(st_q)
      == lcd_pkg::LCD_ST_SCAN |-> idx_q <= last_idx)
      else $error("scan index beyond duty");
   com_step_a: assert property (st_q == lcd_pkg::LCD_ST_SCAN && cfg_ok && disp_tick
      && idx_q < last_idx |=> idx_q == $past(idx_q) + 2'h1)
      else $error("common did not advance on display tick");
   com_hold_a: assert property (st_q == lcd_pkg::LCD_ST_SCAN && !disp_tick |=> $stable(idx_q))
      else $error("common changed without display tick");
   frame_flip_a: assert property ($changed(pol_q) && st_q == lcd_pkg::LCD_ST_SCAN
      |-> $past(disp_tick) && $past(idx_q) >= $past(last_idx))
      else $error("frame polarity changed mid frame");
   pixel_on_a: assert property ($past(st_q) == lcd_pkg::LCD_ST_SCAN && !$past(pol_q)
      && $past(ram_q[4][idx_q]) |-> segment_outputs_level[4] == lcd_pkg::LVL_0)
      else $error("stored one not driven as lit pixel");
   shared_role_a: assert property (shared_segment_outputs_oe[0] == !cs_q[3]
      && internal_supply_sel == shared_segment_outputs_oe)
      else $error("shared pin role mismatch");
   stopped_frozen_a: assert property (!tc_q[lcd_pkg::TC_RUN] && !disp_tick && st_q == lcd_pkg::LCD_ST_SCAN
      ##1 st_q == lcd_pkg::LCD_ST_SCAN |-> $stable(idx_q))
      else $error("scan advanced with timer stopped");
endmodule

// File: core/lcd_pkg.sv
package lcd_pkg;
   localparam int NUM_COM = 4;
   localparam int NUM_SEG = 20;
   localparam int NUM_SHARED = 3;
   localparam int CTL_W = 4;
   localparam logic [1:0] DUTY_NONE = 2'h0;
   localparam logic [1:0] DUTY_HALF = 2'h1;
   localparam logic [1:0] DUTY_THIRD = 2'h2;
   localparam logic [1:0] DUTY_QUARTER = 2'h3;
   localparam int CF_DUTY_LSB = 0;
   localparam int CF_DRIVE_ON = 2;
   localparam int CF_RES_SEL = 3;
   localparam logic [3:0] CF_RESET = 4'h0;
   localparam int CS_RES_CTL = 0;
   localparam int CS_SHARED_TOP = 3;
   localparam logic [3:0] CS_RESET = 4'hF;
   localparam int TC_SRC_SEL = 2;
   localparam int TC_RUN = 3;
   localparam logic [3:0] TC_RESET = 4'h0;
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [1:0] LVL_0 = 2'h0;
   localparam logic [1:0] LVL_1 = 2'h1;
   localparam logic [1:0] LVL_2 = 2'h2;
   localparam logic [1:0] LVL_TOP = 2'h3;
   typedef enum logic [1:0] {
      LCD_ST_OFF = 2'b01,
      LCD_ST_SCAN = 2'b10
   } lcd_state_t;
endpackage

// File: core/lcd_divider.sv
module lcd_divider #(
   parameter int CNT_W = 4
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic src_tick,
   input wire logic [CNT_W-1:0] reload,
   output logic display_clock,
   output logic disp_tick
);
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic clk_q, clk_d, tick_q, tick_d;

   // Divide by reload plus one, then halve
   always_comb begin
      cnt_d = cnt_q;
      clk_d = clk_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
         clk_d = 1'b0;
      end else if (src_tick) begin
         if (cnt_q >= reload) begin
            cnt_d = '0;
            clk_d = ~clk_q;
            tick_d = ~clk_q;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
         tick_q <= tick_d;
      end
   end

   assign display_clock = clk_q;
   assign disp_tick = tick_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   stop_no_clock_a: assert property (!run |=> !display_clock && !disp_tick)
      else $error("display clock ran while timer stopped");
   tick_cause_a: assert property (disp_tick |-> $past(src_tick) && $past(run))
      else $error("display tick without count source");
   tick_rise_a: assert property (disp_tick |-> display_clock && !$past(display_clock))
      else $error("display tick not at clock rise");
   count_bound_a: assert property (run && cnt_q > reload && src_tick |=> cnt_q == '0)
      else $error("divider exceeded reload value");
endmodule

// File: testbench/lcd_panel_model.sv
module lcd_panel_model (
   input wire logic [3:0][1:0] com_lvl,
   input wire logic [3:0] com_oe,
   input wire logic [19:0][1:0] seg_lvl,
   output logic [3:0][19:0] pixel_on
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         for (int s = 0; s < 20; s++) begin
            pixel_on[k][s] = com_oe[k] && ({com_lvl[k], seg_lvl[s]} == 4'hC || {com_lvl[k], seg_lvl[s]} == 4'h3);
         end
      end
   end
endmodule

// File: testbench/lcd_driver_tb_top.sv
module lcd_driver_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, sys_rst, pre, t5, bk, ram_we, dclk, act;
   logic [3:0] we;
   logic [3:0] wd [4];
   logic [4:0] ram_addr;
   logic [3:0] ram_wdata;
   logic [3:0][1:0] com_lvl;
   logic [3:0] com_oe;
   logic [19:0][1:0] seg_lvl;
   logic [2:0] sh_oe, sup_sel;
   logic [1:0] scan_idx;
   logic res_en, res_low;
   logic [3:0][19:0] pix;
   int miscompares, checked, idx, pol, duty;
   int ram [20];
   int seed = 32'hB3510907;

   lcd_driver lcd_driver_i (
      .mclk(mclk), .sys_rst(sys_rst), .prescaler_output(pre), .timer5_bit4(t5), .backup_mode(bk),
      .display_control_first_we(we[0]), .display_control_first_wdata(wd[0]),
      .display_control_second_we(we[1]), .display_control_second_wdata(wd[1]),
      .timer_control_six_we(we[2]), .timer_control_six_wdata(wd[2]),
      .display_divider_timer_we(we[3]), .display_divider_timer_wdata(wd[3]),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .common_outputs_level(com_lvl), .common_outputs_oe(com_oe), .segment_outputs_level(seg_lvl),
      .shared_segment_outputs_oe(sh_oe), .internal_supply_sel(sup_sel), .divider_resistor_en(res_en),
      .divider_resistor_low(res_low), .display_clock(dclk), .display_active(act), .scan_com_index(scan_idx)
   );
   lcd_panel_model lcd_panel_model_i (.com_lvl(com_lvl), .com_oe(com_oe), .seg_lvl(seg_lvl), .pixel_on(pix));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wr(int g, logic [3:0] v);
      we[g] <= 1'b1;
      wd[g] <= v;
      cyc(1);
      we[g] <= 1'b0;
      cyc(1);
   endtask

   task automatic tick();
      pre <= 1'b1;
      cyc(1);
      pre <= 1'b0;
      cyc(4);
   endtask

   task automatic rst_cfg(logic [3:0] tc, logic [3:0] dv);
      sys_rst <= 1'b1;
      cyc(8);
      sys_rst <= 1'b0;
      cyc(1);
      wr(2, tc);
      wr(3, dv);
   endtask

   task automatic chk_scan();
      int hb, on;
      hb = (duty == 1);
      chk("index", scan_idx, idx);
      for (int k = 0; k < 4; k++) begin
         chk("com_oe", com_oe[k], k <= duty);
         if (k <= duty) chk("com_lvl", com_lvl[k], (k == idx) ? (pol ? 0 : 3) : (pol ? 2 - hb : 1));
      end
      for (int s = 0; s < 20; s++) begin
         on = (ram[s] >> idx) & 1;
         chk("seg_lvl", seg_lvl[s], on ? (pol ? 3 : 0) : (pol ? 1 - hb : 2 + hb));
         chk("pixel", pix[idx][s], on);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      cyc(5000);
      miscompares++;
      finish_test();
   end

   initial begin
      {pre, t5, bk, ram_we} = 4'h0;
      we = 4'h0;
      wd = '{default: 4'h0};
      ram_addr = 5'h00;
      ram_wdata = 4'h0;
      sys_rst = 1'b1;
      rst_cfg(4'hC, 4'h0);
      chk("com_lvl", com_lvl, 64'hFF);
      chk("seg_lvl", seg_lvl, 64'hFF_FFFF_FFFF);
      chk("shared_oe", sh_oe, 64'h0);
      chk("res_en", res_en, 64'h0);
      chk("res_low", res_low, 64'h0);
      chk("active", act, 64'h0);
      wr(1, 4'h6);
      chk("shared_oe", sh_oe, 64'h1);
      chk("supply_sel", sup_sel, 64'h1);
      chk("res_en", res_en, 64'h1);
      wr(0, 4'hC);
      cyc(3);
      chk("active", act, 64'h0);
      chk("res_low", res_low, 64'h1);
      for (duty = 1; duty < 4; duty++) begin
         rst_cfg(4'hC, 4'h0);
         wr(1, 4'h0);
         chk("shared_oe", sh_oe, 64'h7);
         chk("supply_sel", sup_sel, 64'h7);
         for (int s = 0; s < 20; s++) begin
            ram[s] = $random(seed) & 15;
            ram_we <= 1'b1;
            ram_addr <= s[4:0];
            ram_wdata <= ram[s][3:0];
            cyc(1);
         end
         ram_we <= 1'b0;
         wr(0, 4'h4 | duty[3:0]);
         cyc(3);
         idx = 0;
         pol = 0;
         chk("active", act, 64'h1);
         chk_scan();
         repeat (2 * (duty + 1) + 1) begin
            tick();
            chk("dclk", dclk, 64'h1);
            idx++;
            if (idx > duty) begin
               idx = 0;
               pol ^= 1;
            end
            chk_scan();
            tick();
            chk("dclk", dclk, 64'h0);
         end
         wr(2, 4'h4);
         tick();
         chk("dclk", dclk, 64'h0);
         chk_scan();
         bk <= 1'b1;
         cyc(3);
         chk("com_lvl", com_lvl, 64'hFF);
         chk("seg_lvl", seg_lvl, 64'hFF_FFFF_FFFF);
         bk <= 1'b0;
      end
      rst_cfg(4'h4, 4'h0);
      tick();
      chk("dclk", dclk, 64'h0);
      rst_cfg(4'h8, 4'h2);
      tick();
      chk("dclk", dclk, 64'h0);
      // Reload lowered below the count still ends the count on the next tick
      for (int i = 1; i <= 6; i++) begin
         if (i == 6) wr(3, 4'h1);
         t5 <= 1'b1;
         cyc(2);
         t5 <= 1'b0;
         cyc(3);
         chk("dclk", dclk, i >= 3 && i < 6);
      end
      finish_test();
   end
endmodule
